/* sps_pkg.sv */
// shared constants and types of the serial peripheral port
package sps_pkg;

  // register byte addresses on the AXI4-Lite bus
  localparam logic [31:0] ADDR_CONTROL_FIRST  = 32'h0000_0000;
  localparam logic [31:0] ADDR_CONTROL_SECOND = 32'h0000_0004;
  localparam logic [31:0] ADDR_FLAGS          = 32'h0000_0008;
  localparam logic [31:0] ADDR_DATA           = 32'h0000_000C;
  localparam logic [31:0] ADDR_PIN_CTRL       = 32'h0000_0010;
  localparam logic [31:0] ADDR_PIN_STAT       = 32'h0000_0014;

  // flag bit positions
  localparam int FL_XFER = 0;
  localparam int FL_WCOL = 1;
  localparam int FL_DRE  = 2;
  localparam int FL_TXC  = 3;
  localparam int FL_RXC  = 4;

  // reset values
  localparam logic [7:0] RST_CONTROL  = 8'h00;
  localparam logic [7:0] RST_PIN_CTRL = 8'h00;

  // half sck period in clocks: div 4, 16, 64, 128, halved by the doubling bit
  localparam logic [6:0] HALF_DIV4   = 7'h02;
  localparam logic [6:0] HALF_DIV16  = 7'h08;
  localparam logic [6:0] HALF_DIV64  = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  localparam logic [4:0] LAST_EDGE   = 5'h0F;
  localparam logic [3:0] LAST_BIT    = 4'h7;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    SPS_IDLE = 1'b0,
    SPS_RUN  = 1'b1
  } sps_phase_t;

  typedef struct packed {
    logic [1:0] spare;
    logic       bit_order_bit;
    logic       master;
    logic [1:0] clock_divider_field;
    logic       clock_doubling_bit;
    logic       enable;
  } sps_ctrl_first_t;

  typedef struct packed {
    logic       buffered_operation_enable;
    logic       buffer_write_option;
    logic [2:0] spare;
    logic       select_line_disable;
    logic [1:0] mode;
  } sps_ctrl_second_t;

  // one bit per serial line
  typedef struct packed {
    logic ss_b;
    logic sck;
    logic miso;
    logic mosi;
  } sps_pins_t;

  typedef struct packed {
    sps_ctrl_first_t  control_first;
    sps_ctrl_second_t control_second;
    logic [7:0]       pin_ctrl;
    sps_pins_t        pin_s1;
    sps_pins_t        pin_s2;
    logic             sck_d;
    logic [7:0]       shift;
    logic             out_bit;
    logic [3:0]       bit_cnt;
    logic [4:0]       edge_cnt;
    logic [6:0]       half_cnt;
    logic             sck_lvl;
    sps_phase_t       phase;
    logic [7:0]       tx_buf;
    logic             tx_full;
    logic [7:0]       rx_first;
    logic             rx_first_ok;
    logic [7:0]       rx_second;
    logic             rx_second_ok;
    logic             flag_xfer;
    logic             flag_wcol;
    logic             flag_txc;
    logic             wake;
    logic             aw_got;
    logic [31:0]      aw_addr;
    logic             w_got;
    logic [7:0]       w_data;
    logic             w_en;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } sps_state_t;

  localparam sps_state_t STATE_RESET = '0;

endpackage : sps_pkg

/* sps_port.sv */
// serial peripheral port, master or slave, with AXI4-Lite registers
`timescale 1ns/1ns

// Contract
// - one 8-bit shift register shifts in on the sample edge; the out bit is updated on the other sck edge
// - data write loads shift register, or transmit buffer when buffered
// - data read returns first receive buffer, or second when buffered
// - master mode has its own serial clock generator
// - slave mode synchronises incoming clock and samples it to advance shifting
// - enabled port forces input direction on master-in or slave-in, clock, select
// - software direction: output drives the line, input leaves it readable
// - slave output drives only while select low, else tri-state
// - master pulls select low first; slave works only while selected
// - data goes out on one line and in on the other simultaneously
// - bit order selectable, least or most significant first
// - seven clock rates from divider field and doubling bit
// - doubled speed with divider 4 runs serial clock at half the peripheral clock
// - write collision flag marks unbuffered data writes during a transfer, buffered ones to a full buffer
// - transfer flag sets when a transmission ends
// - keeps running in idle sleep and gives a wake-up event
// - halts while cpu is halted for debug, runs otherwise
// - everything runs in the peripheral clock domain
// - select line disable makes master ignore its select pin
// - master data write starts clock, shifts eight bits, then sets flag
// - low select input demotes master to slave and sets transfer flag
// - unbuffered write during transfer corrupts byte and sets collision flag
module sps_port (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_b,
  // debug halt from the cpu
  input  wire logic              i_dbg_halt,
  // axi4-lite write
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_awaddr,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  output logic [1:0]             o_bresp,
  // axi4-lite read
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  input  wire logic [31:0]       i_araddr,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  // serial lines
  input  wire sps_pkg::sps_pins_t i_pin,
  output sps_pkg::sps_pins_t     o_pin,
  output sps_pkg::sps_pins_t     o_pin_oe,
  // wake-up event
  output logic                   o_wake
);

  sps_pkg::sps_state_t s;
  sps_pkg::sps_state_t next_s;

  function automatic logic top_bit(input logic [7:0] v, input logic lsb_first);
    top_bit = lsb_first ? v[0] : v[7];
  endfunction : top_bit

  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic lsb_first,
                                          input logic b);
    shift_in = lsb_first ? {b, v[7:1]} : {v[6:0], b};
  endfunction : shift_in

  function automatic logic [6:0] half_period(input logic [1:0] div, input logic dbl);
    logic [6:0] h;
    h = sps_pkg::HALF_DIV4;
    unique case (div)
      2'h0: h = sps_pkg::HALF_DIV4;
      2'h1: h = sps_pkg::HALF_DIV16;
      2'h2: h = sps_pkg::HALF_DIV64;
      2'h3: h = sps_pkg::HALF_DIV128;
    endcase
    half_period = dbl ? {1'b0, h[6:1]} : h;
  endfunction : half_period

  logic       en;
  logic       mst;
  logic       lsb;
  logic       cpol;
  logic       cpha;
  logic       bufd;
  logic       busy;
  logic       tick;
  logic       leading;
  logic       sample;
  logic       done;
  logic       wr_do;
  logic       rd_do;
  logic [7:0] flags;
  logic [7:0] byte_in;

  assign en   = s.control_first.enable;
  assign mst  = s.control_first.master;
  assign lsb  = s.control_first.bit_order_bit;
  assign cpol = s.control_second.mode[1];
  assign cpha = s.control_second.mode[0];
  assign bufd = s.control_second.buffered_operation_enable;
  assign busy = (s.phase == sps_pkg::SPS_RUN) ||
                (!mst && !s.pin_s2.ss_b && s.bit_cnt != 4'h0);
  assign flags = {3'h0, s.rx_second_ok, s.flag_txc, !s.tx_full, s.flag_wcol, s.flag_xfer};
  assign wr_do = s.aw_got && s.w_got && !s.bvalid;
  assign rd_do = i_arvalid && !s.rvalid;

  always_comb begin
    next_s = s;
    tick    = 1'b0;
    leading = 1'b0;
    sample  = 1'b0;
    done    = 1'b0;
    byte_in = s.shift;
    next_s.wake   = 1'b0;
    // two-stage synchronisers on every pin
    next_s.pin_s1 = i_pin;
    next_s.pin_s2 = s.pin_s1;
    next_s.sck_d  = s.pin_s2.sck;

    // axi address and data capture
    if (i_awvalid && !s.aw_got && !s.bvalid) begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = i_awaddr;
    end
    if (i_wvalid && !s.w_got && !s.bvalid) begin
      next_s.w_got  = 1'b1;
      next_s.w_data = i_wdata[7:0];
      next_s.w_en   = i_wstrb[0];
    end
    if (s.bvalid && i_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.rvalid && i_rready) begin
      next_s.rvalid = 1'b0;
    end

    // flag clears by writing one; engine sets below take priority
    if (wr_do && s.w_en && s.aw_addr == sps_pkg::ADDR_FLAGS) begin
      if (s.w_data[sps_pkg::FL_XFER]) next_s.flag_xfer = 1'b0;
      if (s.w_data[sps_pkg::FL_WCOL]) next_s.flag_wcol = 1'b0;
      if (s.w_data[sps_pkg::FL_TXC])  next_s.flag_txc  = 1'b0;
    end

    // register read and its pop of the receive fifo
    if (rd_do) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = sps_pkg::RESP_OKAY;
      next_s.rdata  = 32'h0000_0000;
      unique case (i_araddr)
        sps_pkg::ADDR_CONTROL_FIRST:  next_s.rdata[7:0] = s.control_first;
        sps_pkg::ADDR_CONTROL_SECOND: next_s.rdata[7:0] = s.control_second;
        sps_pkg::ADDR_FLAGS:          next_s.rdata[7:0] = flags;
        sps_pkg::ADDR_PIN_CTRL:       next_s.rdata[7:0] = s.pin_ctrl;
        sps_pkg::ADDR_PIN_STAT:       next_s.rdata[3:0] = s.pin_s2;
        sps_pkg::ADDR_DATA: begin
          if (bufd) begin
            next_s.rdata[7:0]   = s.rx_second;
            next_s.rx_second    = s.rx_first;
            next_s.rx_second_ok = s.rx_first_ok;
            next_s.rx_first_ok  = 1'b0;
          end else begin
            next_s.rdata[7:0] = s.rx_first;
          end
        end
        default: next_s.rresp = sps_pkg::RESP_SLVERR;
      endcase
    end

    // shift engine, frozen while the cpu is halted
    if (!en) begin
      next_s.phase    = sps_pkg::SPS_IDLE;
      next_s.bit_cnt  = 4'h0;
      next_s.sck_lvl  = cpol;
    end else if (!i_dbg_halt) begin
      if (mst) begin
        if (s.phase == sps_pkg::SPS_RUN) begin
          tick = (s.half_cnt == half_period(s.control_first.clock_divider_field,
                                            s.control_first.clock_doubling_bit) - 7'h01);
          next_s.half_cnt = tick ? 7'h00 : s.half_cnt + 7'h01;
          if (tick) begin
            leading         = !s.edge_cnt[0];
            sample          = leading ^ cpha;
            next_s.sck_lvl  = !s.sck_lvl;
            next_s.edge_cnt = s.edge_cnt + 5'h01;
            if (sample) begin
              next_s.shift = shift_in(s.shift, lsb, s.pin_s2.miso);
            end else begin
              next_s.out_bit = top_bit(s.shift, lsb);
            end
            done = (s.edge_cnt == sps_pkg::LAST_EDGE);
          end
        end else if (bufd && s.tx_full) begin
          next_s.shift    = s.tx_buf;
          next_s.tx_full  = 1'b0;
          next_s.out_bit  = top_bit(s.tx_buf, lsb);
          next_s.phase    = sps_pkg::SPS_RUN;
          next_s.half_cnt = 7'h00;
          next_s.edge_cnt = 5'h00;
          next_s.sck_lvl  = cpol;
        end
      end else if (!s.pin_s2.ss_b) begin
        if (s.pin_s2.sck != s.sck_d) begin
          leading = (s.pin_s2.sck != cpol);
          sample  = leading ^ cpha;
          if (sample) begin
            next_s.shift   = shift_in(s.shift, lsb, s.pin_s2.mosi);
            next_s.bit_cnt = s.bit_cnt + 4'h1;
            done           = (s.bit_cnt == sps_pkg::LAST_BIT);
            if (done) next_s.bit_cnt = 4'h0;
          end else begin
            next_s.out_bit = top_bit(s.shift, lsb);
          end
        end
      end else begin
        next_s.bit_cnt = 4'h0;
        next_s.out_bit = top_bit(s.shift, lsb);
        if (bufd && s.tx_full) begin
          next_s.shift   = s.tx_buf;
          next_s.tx_full = 1'b0;
          next_s.out_bit = top_bit(s.tx_buf, lsb);
        end
      end
    end

    // end of a byte: deliver, flag, reload from the transmit buffer
    if (done) begin
      byte_in          = next_s.shift;
      next_s.flag_xfer = 1'b1;
      next_s.wake      = 1'b1;
      if (mst) begin
        next_s.phase   = sps_pkg::SPS_IDLE;
        next_s.sck_lvl = cpol;
      end
      if (bufd) begin
        if (!next_s.rx_second_ok) begin
          next_s.rx_second    = byte_in;
          next_s.rx_second_ok = 1'b1;
        end else begin
          next_s.rx_first    = byte_in;
          next_s.rx_first_ok = 1'b1;
        end
        if (s.tx_full) begin
          next_s.shift   = s.tx_buf;
          next_s.tx_full = 1'b0;
          next_s.out_bit = top_bit(s.tx_buf, lsb);
          if (mst) begin
            next_s.phase    = sps_pkg::SPS_RUN;
            next_s.half_cnt = 7'h00;
            next_s.edge_cnt = 5'h00;
          end
        end else begin
          next_s.flag_txc = 1'b1;
        end
      end else begin
        next_s.rx_first = byte_in;
      end
    end

    // register writes, applied after the engine so they override it
    if (wr_do) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = sps_pkg::RESP_OKAY;
      unique case (s.aw_addr)
        sps_pkg::ADDR_CONTROL_FIRST: begin
          if (s.w_en) next_s.control_first = s.w_data;
        end
        sps_pkg::ADDR_CONTROL_SECOND: begin
          if (s.w_en) next_s.control_second = s.w_data;
        end
        sps_pkg::ADDR_PIN_CTRL: begin
          if (s.w_en) next_s.pin_ctrl = s.w_data;
        end
        sps_pkg::ADDR_FLAGS: begin
        end
        sps_pkg::ADDR_PIN_STAT: begin
        end
        sps_pkg::ADDR_DATA: begin
          if (s.w_en && bufd) begin
            if (next_s.tx_full) next_s.flag_wcol = 1'b1;
            next_s.tx_buf  = s.w_data;
            next_s.tx_full = 1'b1;
          end else if (s.w_en) begin
            next_s.shift = s.w_data;
            if (busy) begin
              next_s.flag_wcol = 1'b1;
            end else begin
              next_s.out_bit = top_bit(s.w_data, lsb);
              if (en && mst) begin
                next_s.phase    = sps_pkg::SPS_RUN;
                next_s.half_cnt = 7'h00;
                next_s.edge_cnt = 5'h00;
                next_s.sck_lvl  = cpol;
              end
            end
          end
        end
        default: next_s.bresp = sps_pkg::RESP_SLVERR;
      endcase
    end

    // another master pulls select low: step down to slave
    if (en && mst && !s.control_second.select_line_disable && !s.pin_ctrl[3] &&
        !s.pin_s2.ss_b) begin
      next_s.control_first.master = 1'b0;
      next_s.flag_xfer            = 1'b1;
      next_s.phase                = sps_pkg::SPS_IDLE;
      next_s.bit_cnt              = 4'h0;
      next_s.sck_lvl              = cpol;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      s <= sps_pkg::STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // bus handshakes and answers
  assign o_awready = !s.aw_got && !s.bvalid;
  assign o_wready  = !s.w_got && !s.bvalid;
  assign o_bvalid  = s.bvalid;
  assign o_bresp   = s.bresp;
  assign o_arready = !s.rvalid;
  assign o_rvalid  = s.rvalid;
  assign o_rdata   = s.rdata;
  assign o_rresp   = s.rresp;
  assign o_wake    = s.wake;

  // pin drive: enabled port overrides the input lines of its role
  always_comb begin
    o_pin.mosi    = (en && mst) ? s.out_bit : s.pin_ctrl[4];
    o_pin.miso    = (en && !mst) ? s.out_bit : s.pin_ctrl[5];
    o_pin.sck     = (en && mst) ? s.sck_lvl : s.pin_ctrl[6];
    o_pin.ss_b    = s.pin_ctrl[7];
    o_pin_oe.mosi = (en && !mst) ? 1'b0 : s.pin_ctrl[0];
    o_pin_oe.sck  = (en && !mst) ? 1'b0 : s.pin_ctrl[2];
    o_pin_oe.ss_b = (en && !mst) ? 1'b0 : s.pin_ctrl[3];
    if (en && mst) begin
      o_pin_oe.miso = 1'b0;
    end else if (en) begin
      o_pin_oe.miso = s.pin_ctrl[1] && !s.pin_s2.ss_b;
    end else begin
      o_pin_oe.miso = s.pin_ctrl[1];
    end
  end

endmodule : sps_port

/* sps_port_chk.sv */
// assertions on the serial port's bus and pin ports
`timescale 1ns/1ns
module sps_port_chk (
  // clock, reset and debug halt
  input wire logic               i_sys_clk,
  input wire logic               i_rst_b,
  input wire logic               i_dbg_halt,
  // register bus
  input wire logic               i_awvalid,
  input wire logic               o_awready,
  input wire logic               i_wvalid,
  input wire logic               o_wready,
  input wire logic               o_bvalid,
  input wire logic               i_bready,
  input wire logic [1:0]         o_bresp,
  input wire logic               i_arvalid,
  input wire logic               o_arready,
  input wire logic               o_rvalid,
  input wire logic               i_rready,
  input wire logic [31:0]        o_rdata,
  // serial lines and wake-up
  input wire sps_pkg::sps_pins_t i_pin,
  input wire sps_pkg::sps_pins_t o_pin_oe,
  input wire logic               o_wake
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_rd_taken;
    i_arvalid && o_arready;
  endsequence

  property p_wr_answer;
    s_wr_taken |-> ##2 o_bvalid;
  endproperty
  property p_b_hold;
    o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
  endproperty
  property p_rd_answer;
    s_rd_taken |=> o_rvalid;
  endproperty
  property p_r_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  property p_r_byte;
    o_rvalid |-> o_rdata[31:8] == 24'h000000;
  endproperty
  property p_wake_pulse;
    o_wake |=> !o_wake;
  endproperty
  // only the slave's forced direction pattern is judged; a disabled port drives miso freely
  property p_miso_tri;
    o_pin_oe.miso && !o_pin_oe.mosi && !o_pin_oe.sck && !o_pin_oe.ss_b |->
      !$past(i_pin.ss_b, 2);
  endproperty
  property p_halt_still;
    $past(i_dbg_halt) |-> !o_wake;
  endproperty

  a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  a_r_byte: assert property (p_r_byte) else $error("read upper bits set");
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake longer than one cycle");
  a_miso_tri: assert property (p_miso_tri) else $error("miso driven while deselected");
  a_halt_still: assert property (p_halt_still) else $error("byte ended while halted");
endmodule : sps_port_chk

bind sps_port sps_port_chk u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_dbg_halt(i_dbg_halt),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
  .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
  .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
  .i_pin(i_pin), .o_pin_oe(o_pin_oe), .o_wake(o_wake)
);

/* sps_slave_model.sv */
// behavioural slave device answering the port in master mode, mode 0, msb first
`timescale 1ns/1ns
module sps_slave_model (
  // clock and lines from the port
  input  wire logic               i_sys_clk,
  input  wire sps_pkg::sps_pins_t i_line,
  input  wire logic               i_sel_b,
  // byte to answer, line driven and byte taken
  input  wire logic [7:0]         i_tx,
  output logic                    o_miso,
  output logic [7:0]              o_rx
);
  logic       sck_d = 1'b0;
  logic       junk = 1'b0;
  logic [7:0] sh = 8'h00;

  // deselected: a changing pattern, never the last bit
  assign o_miso = i_sel_b ? junk : sh[7];
  always @(posedge i_sys_clk) begin
    sck_d <= i_line.sck;
    junk  <= ~junk;
    if (i_sel_b) begin
      sh <= i_tx;
    end else if (!sck_d && i_line.sck) begin
      o_rx <= {o_rx[6:0], i_line.mosi};
    end else if (sck_d && !i_line.sck) begin
      sh <= {sh[6:0], 1'b0};
    end
  end
endmodule : sps_slave_model

/* test_spi_master_slave_port.sv */
// self-checking bench for the serial port over its register bus and pins
`timescale 1ns/1ns
module test_spi_master_slave_port;
  localparam logic [31:0] A_CF = sps_pkg::ADDR_CONTROL_FIRST;
  localparam logic [31:0] A_CS = sps_pkg::ADDR_CONTROL_SECOND;
  localparam logic [31:0] A_FL = sps_pkg::ADDR_FLAGS;
  localparam logic [31:0] A_DT = sps_pkg::ADDR_DATA;
  localparam logic [31:0] A_PC = sps_pkg::ADDR_PIN_CTRL;
  localparam logic [1:0]  OK   = sps_pkg::RESP_OKAY;
  localparam logic [1:0]  ERR  = sps_pkg::RESP_SLVERR;
  localparam logic [7:0]  SLV_RX = 8'hC3;
  logic               clk = 1'b0, rst_b = 1'b0, halt = 1'b0;
  logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic               arvalid = 1'b0, rready = 1'b0;
  logic [31:0]        awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic               ss_b = 1'b1, tsck = 1'b0, tmosi = 1'b0, sel_b = 1'b1;
  logic [7:0]         m_tx = 8'h00, got, cfg;
  logic               awready, wready, bvalid, arready, rvalid, wake, m_miso;
  logic [1:0]         bresp, rresp;
  logic [31:0]        rdata;
  logic [7:0]         m_rx;
  sps_pkg::sps_pins_t pin_in, pin_out, pin_oe;
  int                 mismatches = 0, n_checks = 0, n;

  initial forever #5 clk = ~clk;
  assign pin_in = '{ss_b: ss_b, sck: pin_oe.sck ? pin_out.sck : tsck,
                    miso: pin_oe.miso ? pin_out.miso : m_miso,
                    mosi: pin_oe.mosi ? pin_out.mosi : tmosi};

  sps_port dut (.i_sys_clk(clk), .i_rst_b(rst_b), .i_dbg_halt(halt), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(4'hF), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
    .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_pin(pin_in), .o_pin(pin_out),
    .o_pin_oe(pin_oe), .o_wake(wake));
  sps_slave_model u_slave (.i_sys_clk(clk), .i_line(pin_out), .i_sel_b(sel_b), .i_tx(m_tx),
    .o_miso(m_miso), .o_rx(m_rx));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic give_up(input string what);
    mismatches++;
    $display("[FAIL] %s expected done seen timeout", what);
    complete_run();
  endtask : give_up

  // write one word; the answer is accepted a cycle after it appears
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, tv, td;
    int   k;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tv = bvalid;
      td = bvalid & bready;
      if (td) chk("write response", {30'h0, er}, {30'h0, bresp});
      @(posedge clk);
      if (td) break;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tv) bready <= 1'b1;
    end
    bready <= 1'b0;
    if (k == 100) give_up("write");
  endtask : wr

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic ta, tv, td;
    int   k;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(negedge clk);
      ta = arvalid & arready;
      tv = rvalid;
      td = rvalid & rready;
      if (td) chk("read response", {30'h0, er}, {30'h0, rresp});
      if (td && er === OK) chk("read data", exp, rdata);
      @(posedge clk);
      if (td) break;
      if (ta) arvalid <= 1'b0;
      if (tv) rready <= 1'b1;
    end
    rready <= 1'b0;
    if (k == 100) give_up("read");
  endtask : rdchk

  task automatic wait_wake(output int c);
    for (c = 0; c < 3000; c++) begin
      @(negedge clk);
      if (wake) break;
    end
    if (c == 3000) give_up("byte end");
  endtask : wait_wake

  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int k = 0; k < 8; k++) rev[k] = v[7-k];
  endfunction : rev

  initial begin
    static logic [7:0] cfgs [3] = '{8'h15, 8'h37, 8'h1B};
    static logic [7:0] txv [3]  = '{8'hA5, 8'hC4, 8'h69};
    static logic [7:0] dv [3]   = '{8'h3C, 8'h1E, 8'hF0};
    static int         half [3] = '{8, 4, 16};
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("oe after reset", 32'h0, {28'h0, pin_oe});
    rdchk(A_CF, 32'h0, OK);
    rdchk(A_PC, 32'h0, OK);
    rdchk(A_FL, 32'h04, OK);
    rdchk(32'h0000_0018, 32'h0, ERR);
    wr(32'h0000_0018, 32'h0, ERR);
    $display("test reset done");
    wr(A_PC, 32'h07, OK);
    for (int i = 0; i < 3; i++) begin
      cfg = cfgs[i];
      m_tx <= txv[i];
      wr(A_CF, {24'h0, cfg & 8'hFE}, OK);
      wr(A_CF, {24'h0, cfg}, OK);
      sel_b <= 1'b0;
      wr(A_DT, {24'h0, dv[i]}, OK);
      if (i == 0) begin
        halt <= 1'b1;
        repeat (20) @(posedge clk);
        halt <= 1'b0;
      end
      wait_wake(n);
      chk("oe miso master", 32'h0, {31'h0, pin_oe.miso});
      chk("byte time", 32'h1, {31'h0, n >= 16 * half[i] - 4 && n <= 16 * half[i] + 4});
      sel_b <= 1'b1;
      chk("slave got", {24'h0, cfg[5] ? rev(dv[i]) : dv[i]}, {24'h0, m_rx});
      rdchk(A_DT, {24'h0, cfg[5] ? rev(txv[i]) : txv[i]}, OK);
      rdchk(A_FL, 32'h05, OK);
      wr(A_FL, 32'h01, OK);
      $display("test master %0d done", i);
    end
    wr(A_CF, 32'h00, OK);
    wr(A_CS, 32'h02, OK);
    wr(A_CF, 32'h15, OK);
    chk("sck idle high", 32'h1, {31'h0, pin_out.sck});
    wr(A_CF, 32'h00, OK);
    m_tx <= 8'h96;
    wr(A_CS, 32'h80, OK);
    wr(A_CF, 32'h15, OK);
    sel_b <= 1'b0;
    wr(A_DT, 32'h4B, OK);
    wait_wake(n);
    sel_b <= 1'b1;
    chk("slave got buffered", 32'h4B, {24'h0, m_rx});
    rdchk(A_DT, 32'h96, OK);
    rdchk(A_FL, 32'h0D, OK);
    wr(A_FL, 32'h09, OK);
    wr(A_CF, 32'h00, OK);
    wr(A_CS, 32'h00, OK);
    $display("test buffered done");
    wr(A_CF, 32'h15, OK);
    sel_b <= 1'b0;
    wr(A_DT, 32'h11, OK);
    wr(A_DT, 32'h22, OK);
    wait_wake(n);
    sel_b <= 1'b1;
    rdchk(A_FL, 32'h07, OK);
    wr(A_FL, 32'h03, OK);
    rdchk(A_FL, 32'h04, OK);
    $display("test collision done");
    ss_b <= 1'b0;
    repeat (4) @(posedge clk);
    rdchk(A_CF, 32'h05, OK);
    rdchk(A_FL, 32'h05, OK);
    ss_b <= 1'b1;
    wr(A_FL, 32'h01, OK);
    wr(A_CS, 32'h04, OK);
    wr(A_CF, 32'h15, OK);
    ss_b <= 1'b0;
    repeat (4) @(posedge clk);
    rdchk(A_CF, 32'h15, OK);
    rdchk(A_FL, 32'h04, OK);
    ss_b <= 1'b1;
    $display("test select line done");
    wr(A_CS, 32'h00, OK);
    wr(A_CF, 32'h00, OK);
    wr(A_PC, 32'h03, OK);
    wr(A_CF, 32'h01, OK);
    wr(A_DT, 32'h5A, OK);
    @(negedge clk);
    chk("oe miso deselected", 32'h0, {31'h0, pin_oe.miso});
    ss_b <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("oe miso selected", 32'h1, {31'h0, pin_oe.miso});
    chk("oe mosi slave", 32'h0, {31'h0, pin_oe.mosi});
    for (int b = 7; b >= 0; b--) begin
      @(posedge clk);
      tmosi <= SLV_RX[b];
      repeat (3) @(posedge clk);
      @(negedge clk);
      got[b] = pin_out.miso;
      @(posedge clk);
      tsck <= 1'b1;
      repeat (4) @(posedge clk);
      tsck <= 1'b0;
    end
    repeat (8) @(posedge clk);
    ss_b <= 1'b1;
    chk("slave sent", 32'h5A, {24'h0, got});
    rdchk(A_DT, {24'h0, SLV_RX}, OK);
    $display("test slave done");
    complete_run();
  end
endmodule : test_spi_master_slave_port
